// ==== dv/qsf_host_model.sv ====
/* qsf_host_model: mode 0 serial host driving select, clock and lanes.
   assumes the bench resolves each lane from every drive enable. */
`default_nettype none
module qsf_host_model #(
   parameter int HALF = 3 // clk cycles per half, 8.3 MHz
) (
   // clock
   input  wire logic clk,
   // host pins
   output logic      select_n,
   output logic      sclk,
   output logic      d0,
   output logic      d2,
   output logic      d3,
   output logic      hen,
   // resolved lanes
   input  wire logic l0,
   input  wire logic l1,
   input  wire logic l2,
   input  wire logic l3
);
   timeunit 1ns;
   timeprecision 1ps;

   // select starts low so the first frame must make a fresh fall
   initial
   begin
      select_n = 1'b0;
      sclk = 1'b0;
      d0 = 1'b0;
      d2 = 1'b1;
      d3 = 1'b1;
      hen = 1'b1;
   end

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   // high then low on select, clock idling low
   task automatic start();
      tick(1);
      select_n = 1'b1;
      tick(2);
      select_n = 1'b0;
   endtask

   task automatic stop();
      tick(HALF);
      select_n = 1'b1;
      tick(2);
   endtask

   // msb first, data set on the low half, taken at the rise
   task automatic xbyte(input logic [7:0] tx, input int w,
                        output logic [7:0] rx);
      for (int i = 7; i >= 0; i -= w)
      begin
         d0 = tx[i];
         tick(HALF);
         sclk = 1'b1;
         if (w == 1)
            rx[i] = l1;
         else if (w == 2)
            rx[i-:2] = {l1, l0};
         else
            rx[i-:4] = {l3, l2, l1, l0};
         tick(HALF);
         sclk = 1'b0;
      end
   endtask
endmodule // qsf_host_model
`default_nettype wire

// ==== dv/qsf_pin_if_checker.sv ====
/* qsf_pin_if_checker: pin-level assertions for qsf_pin_if.
   assumes serial clock half periods of at least two clk cycles. */
`default_nettype none
module qsf_pin_if_checker #(
   parameter int BUSY_CYCLES = 64
) (
   // clock and reset
   input wire logic clk,
   input wire logic reset,
   // host side pins
   input wire logic select_n_pin,
   input wire logic sclk_pin,
   input wire logic lane_3_in,
   // device drive
   input wire logic lane_0_oe,
   input wire logic lane_1_oe,
   input wire logic lane_1_out,
   input wire logic lane_2_oe,
   input wire logic lane_3_oe,
   input wire logic busy,
   input wire logic four_lane_enable
);
   int unsigned busy_cnt;

   default clocking dc @(posedge clk); endclocking
   default disable iff (reset);

   // length of the current busy stretch, bounds the internal operation
   always_ff @(posedge clk)
   begin
      if (reset || !busy)
         busy_cnt <= 0;
      else
         busy_cnt <= busy_cnt + 1;
   end

   property p_desel;
      select_n_pin && $past(select_n_pin) |->
         !(lane_0_oe || lane_1_oe || lane_2_oe || lane_3_oe);
   endproperty
   a_desel: assert property (p_desel)
      else $error("lane driven while deselected");

   property p_pause;
      !four_lane_enable && !lane_3_in && !select_n_pin |-> !lane_1_oe;
   endproperty
   a_pause: assert property (p_pause)
      else $error("output driven while paused");

   property p_nquad;
      !four_lane_enable |-> !lane_2_oe && !lane_3_oe;
   endproperty
   a_nquad: assert property (p_nquad)
      else $error("upper lanes driven with quad off");

   property p_fall;
      lane_1_oe && $past(lane_1_oe) && $changed(lane_1_out) |->
         $past(sclk_pin, 2) && !$past(sclk_pin);
   endproperty
   a_fall: assert property (p_fall)
      else $error("output moved without a clock fall");

   property p_bstart;
      $rose(busy) |-> $past(select_n_pin);
   endproperty
   a_bstart: assert property (p_bstart)
      else $error("busy began while selected");

   property p_bbound;
      busy |-> busy_cnt <= BUSY_CYCLES;
   endproperty
   a_bbound: assert property (p_bbound)
      else $error("busy lasted too long");

   property p_oelate;
      $fell(select_n_pin) |-> !lane_1_oe [*8];
   endproperty
   a_oelate: assert property (p_oelate)
      else $error("output before command complete");

   property p_quad;
      lane_2_oe |-> lane_0_oe && lane_1_oe && lane_3_oe;
   endproperty
   a_quad: assert property (p_quad)
      else $error("quad lanes not driven together");
endmodule // qsf_pin_if_checker

bind qsf_pin_if qsf_pin_if_checker #(.BUSY_CYCLES(BUSY_CYCLES)) u_chk (
   .clk(clk),
   .reset(reset),
   .select_n_pin(select_n_pin),
   .sclk_pin(sclk_pin),
   .lane_3_in(lane_3_in),
   .lane_0_oe(lane_0_oe),
   .lane_1_oe(lane_1_oe),
   .lane_1_out(lane_1_out),
   .lane_2_oe(lane_2_oe),
   .lane_3_oe(lane_3_oe),
   .busy(busy),
   .four_lane_enable(four_lane_enable)
);
`default_nettype wire

// ==== dv/qsf_pin_if_tb_top.sv ====
/* qsf_pin_if_tb_top: self-checking bench for qsf_pin_if.
   assumes the host model paces the serial clock well below 80 MHz. */
`default_nettype none
module qsf_pin_if_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int BUSY = 200;
   localparam logic [63:0] UID = 64'h5a5a_0f0f_c3c3_9696; // arbitrary

   logic       clk = 1'b0;
   logic       reset = 1'b1;
   logic       flip = 1'b0;
   logic [7:0] rx;
   int         fail_count = 0;
   int         cmp_count = 0;
   int         cyc = 0;
   wire logic  sel_n, sclk, d0, d2, d3, hen;
   wire logic  l0, l1, l2, l3;
   wire logic  o0, o1, o2, o3, e0, e1, e2, e3, busy, qe;

   always #10 clk = ~clk;

   // released lanes toggle so a stale level never reads as data
   always @(posedge clk) flip <= ~flip;
   assign l0 = e0 ? o0 : hen ? d0 : flip;
   assign l1 = e1 ? o1 : flip;
   assign l2 = e2 ? o2 : hen ? d2 : flip;
   assign l3 = e3 ? o3 : hen ? d3 : flip;

   qsf_host_model host (.clk(clk), .select_n(sel_n), .sclk(sclk),
      .d0(d0), .d2(d2), .d3(d3), .hen(hen),
      .l0(l0), .l1(l1), .l2(l2), .l3(l3));

   qsf_pin_if #(.BUSY_CYCLES(BUSY), .UNIQUE_ID(UID)) dut (
      .clk(clk), .reset(reset), .select_n_pin(sel_n), .sclk_pin(sclk),
      .lane_0_in(l0), .lane_0_out(o0), .lane_0_oe(e0),
      .lane_1_in(l1), .lane_1_out(o1), .lane_1_oe(e1),
      .lane_2_in(l2), .lane_2_out(o2), .lane_2_oe(e2),
      .lane_3_in(l3), .lane_3_out(o3), .lane_3_oe(e3),
      .busy(busy), .four_lane_enable(qe));

   task automatic final_report();
      $display("compares %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   // hang guard well above the few thousand cycles needed
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 40000)
      begin
         fail_count++;
         final_report();
      end
   end

   task automatic chk(input string nm, input logic [7:0] ex,
                      input logic [7:0] got);
      cmp_count++;
      if (got !== ex)
      begin
         $display("BAD %s exp %h got %h", nm, ex, got);
         fail_count++;
      end
   endtask

   task automatic op1(input logic [7:0] op);
      host.start();
      host.xbyte(op, 1, rx);
   endtask

   task automatic hdr(input logic [7:0] op, input logic [23:0] a);
      op1(op);
      for (int i = 2; i >= 0; i--)
         host.xbyte(a[8*i+:8], 1, rx);
   endtask

   task automatic get(input int w, input logic [7:0] ex, input string nm);
      host.xbyte(8'h00, w, rx);
      chk(nm, ex, rx);
   endtask

   task automatic en();
      op1(qsf_pkg::OP_WREN);
      host.stop();
   endtask

   // wait out an internal operation, bounded
   task automatic idle();
      int n;
      n = 0;
      while (busy !== 1'b0 && n < 400)
      begin
         @(posedge clk);
         n++;
      end
      chk("idle", 8'h00, {7'h00, busy});
   endtask

   // select low from power-up must not start a command
   task automatic t_first();
      chk("rst_oe", 8'h00, {4'h0, e3, e2, e1, e0});
      chk("rst_qe", 8'h00, {7'h00, qe});
      host.xbyte(qsf_pkg::OP_RDSR1, 1, rx);
      host.xbyte(8'h00, 1, rx);
      chk("nofall", 8'h00, {7'h00, e1});
      host.stop();
   endtask

   // status read on the single output lane, then write enable
   task automatic t_status();
      op1(qsf_pkg::OP_RDSR1);
      get(1, 8'h00, "sr1");
      chk("lanes", 8'h02, {4'h0, e3, e2, e1, e0});
      host.stop();
      chk("desel", 8'h00, {4'h0, e3, e2, e1, e0});
      en();
      op1(qsf_pkg::OP_RDSR1);
      get(1, 8'h02, "wel");
      host.stop();
   endtask

   // erase, program wrapping at the page end, read back
   task automatic t_prog();
      en();
      hdr(qsf_pkg::OP_SE, 24'h000000);
      host.stop();
      chk("busy", 8'h01, {7'h00, busy});
      op1(qsf_pkg::OP_RDSR1);
      get(1, 8'h03, "sr_busy");
      host.stop();
      idle();
      en();
      hdr(qsf_pkg::OP_PP, 24'h0000ff);
      host.xbyte(8'ha5, 1, rx);
      host.xbyte(8'h3c, 1, rx);
      host.stop();
      idle();
      hdr(qsf_pkg::OP_READ, 24'h0000ff);
      get(1, 8'ha5, "rd_ff");
      get(1, 8'hff, "rd_100");
      host.stop();
      hdr(qsf_pkg::OP_FAST, 24'h000000);
      host.xbyte(8'h00, 1, rx);
      get(1, 8'h3c, "wrap");
      host.stop();
      hdr(qsf_pkg::OP_DUAL, 24'h0000ff);
      host.xbyte(8'h00, 1, rx);
      get(2, 8'ha5, "dual");
      host.stop();
   endtask

   // protect pin low with srp0 set refuses a status write
   task automatic t_wp();
      en();
      op1(qsf_pkg::OP_WRSR);
      host.xbyte(8'h80, 1, rx);
      host.stop();
      idle();
      host.d2 = 1'b0;
      en();
      op1(qsf_pkg::OP_WRSR);
      host.xbyte(8'h00, 1, rx);
      host.stop();
      host.d2 = 1'b1;
      op1(qsf_pkg::OP_RDSR1);
      get(1, 8'h82, "wp");
      host.stop();
   endtask

   // pause mid-read releases the output and freezes shifting
   task automatic t_pause();
      hdr(qsf_pkg::OP_READ, 24'h0000ff);
      host.d3 = 1'b0;
      host.tick(1);
      chk("pause_oe", 8'h00, {7'h00, e1});
      host.xbyte(8'h00, 1, rx);
      host.d3 = 1'b1;
      get(1, 8'ha5, "resume");
      host.stop();
   endtask

   task automatic t_uid();
      op1(qsf_pkg::OP_UID);
      repeat (4) host.xbyte(8'h00, 1, rx);
      get(1, UID[63:56], "uid0");
      get(1, UID[55:48], "uid1");
      host.stop();
   endtask

   // quad read refused, then enabled and read on four lanes
   task automatic t_quad();
      hdr(qsf_pkg::OP_QUAD, 24'h0000ff);
      host.xbyte(8'h00, 1, rx);
      host.xbyte(8'h00, 1, rx);
      chk("q_off", 8'h00, {4'h0, e3, e2, e1, e0});
      host.stop();
      en();
      op1(qsf_pkg::OP_WRSR);
      host.xbyte(8'h00, 1, rx);
      host.xbyte(8'h02, 1, rx);
      host.stop();
      idle();
      chk("qe", 8'h01, {7'h00, qe});
      hdr(qsf_pkg::OP_QUAD, 24'h0000ff);
      host.xbyte(8'h00, 1, rx);
      host.hen = 1'b0;
      get(4, 8'ha5, "quad");
      chk("q_lanes", 8'h0f, {4'h0, e3, e2, e1, e0});
      host.stop();
      host.hen = 1'b1;
   endtask

   // main sequence
   initial
   begin
      repeat (4) @(posedge clk);
      #1;
      reset = 1'b0;
      t_first();
      t_status();
      t_prog();
      t_pause();
      t_uid();
      t_wp();
      t_quad();
      final_report();
   end
endmodule // qsf_pin_if_tb_top
`default_nettype wire

// ==== rtl/qsf_pin_if.sv ====
/*
 * qsf_pin_if: serial flash device behind its select, clock and four lanes.
 * Assumes the serial clock and pins are synchronous to clk and that each
 * serial clock half period lasts at least two clk cycles.
 */
`default_nettype none
module qsf_pin_if #(
   parameter int          MEM_BYTES   = 8192,
   parameter int          ARRAY_PAGES = qsf_pkg::PAGES_8M,
   parameter int          BUSY_CYCLES = qsf_pkg::BUSY_CYCLES,
   parameter logic        QE_RESET    = 1'b0,
   parameter logic [63:0] UNIQUE_ID   = qsf_pkg::UID_DEFAULT
) (
   // clock and reset
   input  wire logic clk,
   input  wire logic reset,
   // serial control
   input  wire logic select_n_pin,
   input  wire logic sclk_pin,
   // lane 0, also serial_in_pin
   input  wire logic lane_0_in,
   output logic      lane_0_out,
   output logic      lane_0_oe,
   // lane 1, also serial_out_pin
   input  wire logic lane_1_in,
   output logic      lane_1_out,
   output logic      lane_1_oe,
   // lane 2, also write_protect_n_pin
   input  wire logic lane_2_in,
   output logic      lane_2_out,
   output logic      lane_2_oe,
   // lane 3, also pause_n_pin
   input  wire logic lane_3_in,
   output logic      lane_3_out,
   output logic      lane_3_oe,
   // status view
   output logic      busy,
   output logic      four_lane_enable
);
   localparam int AW = $clog2(MEM_BYTES);
   localparam int CAP_BYTES = ARRAY_PAGES * qsf_pkg::PAGE_BYTES;
   localparam logic [23:0] CAP_MASK = 24'(CAP_BYTES - 1);
   localparam logic [23:0] SECT_MASK =
      24'(qsf_pkg::SECTOR_PAGES * qsf_pkg::PAGE_BYTES - 1);
   localparam logic [23:0] B32_MASK =
      24'(qsf_pkg::BLK32_PAGES * qsf_pkg::PAGE_BYTES - 1);
   localparam logic [23:0] B64_MASK =
      24'(qsf_pkg::BLK64_PAGES * qsf_pkg::PAGE_BYTES - 1);
   localparam logic [11:0] BUSY_LOAD = 12'(BUSY_CYCLES);

   qsf_pkg::qsf_state_e state;
   qsf_pkg::qsf_pend_e  pend;
   logic        sclk_q;
   logic        sel_q;
   logic        active;
   logic [7:0]  opcode;
   logic [7:0]  rx;
   logic [5:0]  bitcnt;
   logic [23:0] addr;
   logic [2:0]  in_w;
   logic [7:0]  tx;
   logic [3:0]  out_cnt;
   logic        loaded;
   logic [23:0] rd_ptr;
   logic        wel;
   logic [4:0]  prot;
   logic        srp0;
   logic        srp1;
   logic [7:0]  stage1;
   logic [7:0]  stage2;
   logic [1:0]  stage_cnt;
   logic [11:0] busy_cnt;
   logic [7:0]  mem [MEM_BYTES];

   logic        rise;
   logic        fall;
   logic        hold;
   logic        step;
   logic        cs_fall;
   logic        cs_rise;
   logic [3:0]  in_bits;
   logic [7:0]  rx_next;
   logic [5:0]  cnt_next;
   logic        cmd_done;
   logic        byte_done;
   logic [2:0]  out_w;
   logic [7:0]  sr1;
   logic [7:0]  sr2;
   logic [7:0]  src_byte;
   logic        op_go;
   logic [23:0] er_mask;
   logic [23:0] rd_at;

   // edge detect; pins are synchronous so no synchroniser is needed.
   // the core follows sclk only up to a quarter of clk, far below the
   // 80 MHz the pins allow
   assign rise    = sclk_pin & ~sclk_q;
   assign fall    = ~sclk_pin & sclk_q;
   // sel_q resets low, so a select held low from reset is no falling edge
   assign cs_fall = sel_q & ~select_n_pin;
   assign cs_rise = active & select_n_pin;
   // pause only exists while the lane is not claimed by quad use
   assign hold    = active & ~four_lane_enable & ~lane_3_in;
   assign step    = rise & active & ~hold & (state != qsf_pkg::ST_IDLE);

   // status images
   assign sr1 = {srp0, prot, wel, busy};
   assign sr2 = {6'h00, four_lane_enable, srp1};

   // incoming bits by lane width
   always_comb
   begin
      in_bits  = 4'h0;
      rx_next  = {rx[6:0], lane_0_in};
      cnt_next = bitcnt + 6'h01;
      if (in_w == 3'd4)
      begin
         in_bits  = {lane_3_in, lane_2_in, lane_1_in, lane_0_in};
         rx_next  = {rx[3:0], in_bits};
         cnt_next = bitcnt + 6'h04;
      end
      else if (in_w == 3'd2)
      begin
         in_bits  = {2'b00, lane_1_in, lane_0_in};
         rx_next  = {rx[5:0], in_bits[1:0]};
         cnt_next = bitcnt + 6'h02;
      end
   end

   assign cmd_done  = step & (state == qsf_pkg::ST_CMD) &
                      (cnt_next[4:0] == qsf_pkg::CMD_BITS);
   assign byte_done = step & (state == qsf_pkg::ST_DATA) &
                      (cnt_next[3:0] == qsf_pkg::BYTE_BITS);

   // the first fetch comes one cycle after the last address bit lands,
   // before rd_ptr has caught up, so it reads addr directly
   assign rd_at = loaded ? rd_ptr : addr;

   // output width and read source
   always_comb
   begin
      out_w = 3'd1;
      if (opcode == qsf_pkg::OP_DUAL)
         out_w = 3'd2;
      else if (opcode == qsf_pkg::OP_QUAD)
         out_w = 3'd4;
      if (opcode == qsf_pkg::OP_RDSR1)
         src_byte = sr1;
      else if (opcode == qsf_pkg::OP_RDSR2)
         src_byte = sr2;
      else if (opcode == qsf_pkg::OP_UID)
         src_byte = UNIQUE_ID[8'(63 - 8 * rd_at[2:0]) -: 8];
      else
         src_byte = mem[rd_at[AW-1:0]];
   end

   // selection tracking
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         sclk_q <= 1'b0;
         sel_q  <= 1'b0;
         active <= 1'b0;
      end
      else
      begin
         sclk_q <= sclk_pin;
         sel_q  <= select_n_pin;
         if (select_n_pin)
            active <= 1'b0;
         else if (cs_fall)
            active <= 1'b1;
      end
   end

   // command, address, dummy and input data sequencing
   always_ff @(posedge clk)
   begin
      if (reset || !active)
      begin
         state  <= qsf_pkg::ST_IDLE;
         opcode <= 8'h00;
         rx     <= 8'h00;
         bitcnt <= 6'h00;
         addr   <= 24'h000000;
         in_w   <= 3'd1;
         if (!reset && cs_fall)
            state <= qsf_pkg::ST_CMD;
      end
      else if (step)
      begin
         case (state)
            qsf_pkg::ST_CMD:
            begin
               rx     <= rx_next; // msb first, single lane
               bitcnt <= cnt_next;
               if (cmd_done)
               begin
                  opcode <= rx_next;
                  bitcnt <= 6'h00;
                  state  <= qsf_pkg::ST_SKIP;
                  if (rx_next == qsf_pkg::OP_RDSR1 ||
                      rx_next == qsf_pkg::OP_RDSR2)
                     state <= qsf_pkg::ST_OUT;
                  else if (busy)
                     state <= qsf_pkg::ST_SKIP;
                  else if (rx_next == qsf_pkg::OP_QUAD ||
                           rx_next == qsf_pkg::OP_QPP)
                     state <= four_lane_enable ? qsf_pkg::ST_ADDR
                                               : qsf_pkg::ST_SKIP;
                  else if (rx_next == qsf_pkg::OP_READ ||
                           rx_next == qsf_pkg::OP_FAST ||
                           rx_next == qsf_pkg::OP_DUAL ||
                           rx_next == qsf_pkg::OP_PP ||
                           rx_next == qsf_pkg::OP_SE ||
                           rx_next == qsf_pkg::OP_BE32 ||
                           rx_next == qsf_pkg::OP_BE64)
                     state <= qsf_pkg::ST_ADDR;
                  else if (rx_next == qsf_pkg::OP_UID)
                     state <= qsf_pkg::ST_DUMMY;
                  else if (rx_next == qsf_pkg::OP_WRSR)
                     state <= qsf_pkg::ST_DATA;
               end
            end
            qsf_pkg::ST_ADDR:
            begin
               addr   <= {addr[22:0], lane_0_in} & CAP_MASK;
               bitcnt <= cnt_next;
               if (cnt_next[4:0] == qsf_pkg::ADDR_BITS)
               begin
                  bitcnt <= 6'h00;
                  if (opcode == qsf_pkg::OP_READ)
                     state <= qsf_pkg::ST_OUT;
                  else if (opcode == qsf_pkg::OP_PP)
                     state <= qsf_pkg::ST_DATA;
                  else if (opcode == qsf_pkg::OP_QPP)
                  begin
                     state <= qsf_pkg::ST_DATA;
                     in_w  <= 3'd4;
                  end
                  else if (opcode == qsf_pkg::OP_FAST ||
                           opcode == qsf_pkg::OP_DUAL ||
                           opcode == qsf_pkg::OP_QUAD)
                     state <= qsf_pkg::ST_DUMMY;
                  else
                     state <= qsf_pkg::ST_SKIP;
               end
            end
            qsf_pkg::ST_DUMMY:
            begin
               bitcnt <= cnt_next;
               if ((opcode == qsf_pkg::OP_UID &&
                    cnt_next == qsf_pkg::UID_DUMMY_CLKS) ||
                   (opcode != qsf_pkg::OP_UID &&
                    cnt_next == qsf_pkg::FAST_DUMMY_CLKS))
                  state <= qsf_pkg::ST_OUT;
            end
            qsf_pkg::ST_DATA:
            begin
               rx     <= rx_next;
               bitcnt <= cnt_next;
               if (byte_done)
               begin
                  bitcnt <= 6'h00;
                  // program stays inside its page
                  addr   <= {addr[23:8], addr[7:0] + 8'h01};
               end
            end
            default: ;
         endcase
      end
   end

   // serial output; lanes change on falling clock edges
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         tx         <= 8'h00;
         out_cnt    <= 4'h0;
         loaded     <= 1'b0;
         rd_ptr     <= 24'h000000;
         lane_0_out <= 1'b0;
         lane_1_out <= 1'b0;
         lane_2_out <= 1'b0;
         lane_3_out <= 1'b0;
      end
      else if (state != qsf_pkg::ST_OUT)
      begin
         out_cnt <= 4'h0;
         loaded  <= 1'b0;
         rd_ptr  <= addr;
      end
      else if (!loaded)
      begin
         tx     <= src_byte;
         loaded <= 1'b1;
         rd_ptr <= (addr + 24'h000001) & CAP_MASK;
      end
      else if (fall && !hold)
      begin
         if (out_w == 3'd4)
            {lane_3_out, lane_2_out, lane_1_out, lane_0_out} <= tx[7:4];
         else if (out_w == 3'd2)
            {lane_1_out, lane_0_out} <= tx[7:6];
         else
            lane_1_out <= tx[7];
         if (out_cnt + 4'(out_w) == qsf_pkg::BYTE_BITS)
         begin
            tx      <= src_byte;
            out_cnt <= 4'h0;
            rd_ptr  <= (rd_ptr + 24'h000001) & CAP_MASK;
         end
         else
         begin
            tx      <= tx << out_w;
            out_cnt <= out_cnt + 4'(out_w);
         end
      end
   end

   // enables: released while deselected or paused
   // a mode 3 start puts a falling edge first; it lands in the command
   // phase and is harmless
   always_comb
   begin
      lane_0_oe = 1'b0;
      lane_1_oe = 1'b0;
      lane_2_oe = 1'b0;
      lane_3_oe = 1'b0;
      if (active && !hold && state == qsf_pkg::ST_OUT && loaded)
      begin
         lane_1_oe = 1'b1;
         lane_0_oe = (out_w != 3'd1);
         lane_2_oe = (out_w == 3'd4);
         lane_3_oe = (out_w == 3'd4);
      end
   end

   // an operation starts at deselect only when write enabled and idle
   assign op_go = cs_rise & wel & ~busy & (pend != qsf_pkg::PD_NONE);

   // status, pending operation and busy timer
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         pend             <= qsf_pkg::PD_NONE;
         wel              <= 1'b0;
         prot             <= qsf_pkg::PROT_RESET;
         srp0             <= 1'b0;
         srp1             <= 1'b0;
         four_lane_enable <= QE_RESET;
         stage1           <= 8'h00;
         stage2           <= 8'h00;
         stage_cnt        <= 2'h0;
         busy             <= 1'b0;
         busy_cnt         <= 12'h000;
      end
      else
      begin
         if (cs_fall)
         begin
            pend      <= qsf_pkg::PD_NONE;
            stage_cnt <= 2'h0;
         end
         if (cmd_done && !busy)
         begin
            if (rx_next == qsf_pkg::OP_WREN)
               wel <= 1'b1;
            else if (rx_next == qsf_pkg::OP_WRDI)
               wel <= 1'b0;
            else if (rx_next == qsf_pkg::OP_CE1 ||
                     rx_next == qsf_pkg::OP_CE2)
               pend <= qsf_pkg::PD_CHIP;
         end
         if (step && state == qsf_pkg::ST_ADDR &&
             cnt_next[4:0] == qsf_pkg::ADDR_BITS)
         begin
            if (opcode == qsf_pkg::OP_SE)
               pend <= qsf_pkg::PD_SE;
            else if (opcode == qsf_pkg::OP_BE32)
               pend <= qsf_pkg::PD_B32;
            else if (opcode == qsf_pkg::OP_BE64)
               pend <= qsf_pkg::PD_B64;
         end
         if (byte_done && opcode == qsf_pkg::OP_WRSR)
         begin
            // protect pin low with srp0 locks the status while four_lane_enable is off
            if (!(srp0 && !lane_2_in && !four_lane_enable))
               pend <= qsf_pkg::PD_WRSR;
            if (stage_cnt == 2'h0)
               stage1 <= rx_next;
            else if (stage_cnt == 2'h1)
               stage2 <= rx_next;
            if (stage_cnt != 2'h2)
               stage_cnt <= stage_cnt + 2'h1;
         end
         else if (byte_done)
            pend <= qsf_pkg::PD_PROG;
         // once started the timer ignores select
         if (op_go)
         begin
            busy     <= 1'b1;
            busy_cnt <= BUSY_LOAD;
            if (pend == qsf_pkg::PD_WRSR)
            begin
               prot <= stage1[6:2];
               srp0 <= stage1[qsf_pkg::SR1_SRP0];
               if (stage_cnt == 2'h2)
               begin
                  srp1             <= stage2[qsf_pkg::SR2_SRP1];
                  four_lane_enable <= stage2[qsf_pkg::SR2_QE];
               end
            end
         end
         else if (busy)
         begin
            busy_cnt <= busy_cnt - 12'h001;
            if (busy_cnt == 12'h001)
            begin
               busy <= 1'b0;
               wel  <= 1'b0;
            end
         end
      end
   end

   // erase window around the latched address
   always_comb
   begin
      er_mask = CAP_MASK;
      if (pend == qsf_pkg::PD_SE)
         er_mask = SECT_MASK;
      else if (pend == qsf_pkg::PD_B32)
         er_mask = B32_MASK;
      else if (pend == qsf_pkg::PD_B64)
         er_mask = B64_MASK;
   end

   // storage: program clears bits, erase sets bytes to ff; the backing
   // store is smaller than the address space and aliases onto it
   always_ff @(posedge clk)
   begin
      if (byte_done && opcode != qsf_pkg::OP_WRSR && wel && !busy)
         mem[addr[AW-1:0]] <= mem[addr[AW-1:0]] & rx_next;
      else if (op_go && pend != qsf_pkg::PD_PROG &&
               pend != qsf_pkg::PD_WRSR)
      begin
         for (int i = 0; i < MEM_BYTES; i++)
         begin
            if (((24'(i) ^ addr) & ~er_mask & 24'(MEM_BYTES - 1)) ==
                24'h000000)
               mem[i] <= 8'hff;
         end
      end
   end
endmodule // qsf_pin_if
`default_nettype wire

// ==== rtl/qsf_pkg.sv ====
/*
 * qsf_pkg: shared constants for the serial flash pin interface.
 * Assumes a single system clock; all pin inputs arrive synchronous to it.
 */
`default_nettype none
package qsf_pkg;
   // instruction codes
   localparam logic [7:0] OP_WREN  = 8'h06;
   localparam logic [7:0] OP_WRDI  = 8'h04;
   localparam logic [7:0] OP_RDSR1 = 8'h05;
   localparam logic [7:0] OP_RDSR2 = 8'h35;
   localparam logic [7:0] OP_WRSR  = 8'h01;
   localparam logic [7:0] OP_READ  = 8'h03;
   localparam logic [7:0] OP_FAST  = 8'h0b;
   localparam logic [7:0] OP_DUAL  = 8'h3b;
   localparam logic [7:0] OP_QUAD  = 8'h6b;
   localparam logic [7:0] OP_PP    = 8'h02;
   localparam logic [7:0] OP_QPP   = 8'h32;
   localparam logic [7:0] OP_SE    = 8'h20;
   localparam logic [7:0] OP_BE32  = 8'h52;
   localparam logic [7:0] OP_BE64  = 8'hd8;
   localparam logic [7:0] OP_CE1   = 8'hc7;
   localparam logic [7:0] OP_CE2   = 8'h60;
   localparam logic [7:0] OP_UID   = 8'h4b;
   // array geometry
   localparam int PAGE_BYTES   = 256;
   localparam int SECTOR_PAGES = 16;
   localparam int BLK32_PAGES  = 128;
   localparam int BLK64_PAGES  = 256;
   localparam int PAGES_8M     = 4096;
   localparam int PAGES_16M    = 8192;
   localparam int PAGES_32M    = 16384;
   localparam int SECTORS_8M   = 256;
   localparam int SECTORS_16M  = 512;
   localparam int SECTORS_32M  = 1024;
   localparam int BLOCKS_8M    = 16;
   localparam int BLOCKS_16M   = 32;
   localparam int BLOCKS_32M   = 64;
   // serial framing
   localparam logic [4:0] CMD_BITS  = 5'h08;
   localparam logic [4:0] ADDR_BITS = 5'h18;
   localparam logic [5:0] FAST_DUMMY_CLKS = 6'h08;
   localparam logic [5:0] UID_DUMMY_CLKS  = 6'h20;
   localparam logic [3:0] BYTE_BITS = 4'h8;
   // timing
   localparam int CLK_MHZ      = 50;
   localparam int SCLK_MAX_MHZ = 80;
   localparam int BUSY_CYCLES  = 64;
   // status bit positions
   localparam int SR1_BUSY = 0;
   localparam int SR1_WEL  = 1;
   localparam int SR1_SRP0 = 7;
   localparam int SR2_SRP1 = 0;
   localparam int SR2_QE   = 1;
   localparam logic [4:0] PROT_RESET = 5'h00;
   // arbitrary unique serial number
   localparam logic [63:0] UID_DEFAULT = 64'h0123_4567_89ab_cdef;

   typedef enum logic [2:0] {
      ST_IDLE  = 3'b000,
      ST_CMD   = 3'b001,
      ST_ADDR  = 3'b011,
      ST_DUMMY = 3'b010,
      ST_OUT   = 3'b110,
      ST_DATA  = 3'b111,
      ST_SKIP  = 3'b101
   } qsf_state_e;

   typedef enum logic [2:0] {
      PD_NONE = 3'b000,
      PD_PROG = 3'b001,
      PD_WRSR = 3'b010,
      PD_SE   = 3'b011,
      PD_B32  = 3'b100,
      PD_B64  = 3'b101,
      PD_CHIP = 3'b110
   } qsf_pend_e;
endpackage
`default_nettype wire
